// *** pkg/ddi_pkg.sv ***
// ddi_pkg: shared constants for the memory device command model.
// assumes: imported by the device top and the testbench.
package ddi_pkg;
  // apb register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_MODE = 8'h08;
  localparam logic [7:0] REG_ERR = 8'h0C;
  // control register fields and reset value
  localparam int CTRL_EN_BIT = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  // error register fields (write one to clear)
  localparam int ERR_IDLE_BIT = 0;
  localparam int ERR_EARLY_BIT = 1;
  // command codes on {ras_n, cas_n, we_n} while chip select is low
  localparam logic [2:0] CMD_MODE = 3'h0;
  localparam logic [2:0] CMD_REFRESH = 3'h1;
  localparam logic [2:0] CMD_PRECHARGE = 3'h2;
  localparam logic [2:0] CMD_ACTIVATE = 3'h3;
  localparam logic [2:0] CMD_WRITE = 3'h4;
  localparam logic [2:0] CMD_READ = 3'h5;
  // address bit positions
  localparam int DLL_RESET_BIT = 8;
  localparam int AUTO_PRECHARGE_SELECT_BIT = 10;
  localparam int DRIVE_CAL_LSB = 7;
  localparam int BL_LSB = 0;
  localparam int CL_LSB = 4;
  localparam int AL_LSB = 3;
  // bank select codes for mode loads
  localparam logic [1:0] SEL_MAIN = 2'h0;
  localparam logic [1:0] SEL_EXT = 2'h2;
  // burst length code for eight, and reset mode values
  localparam logic [2:0] BL8_CODE = 3'h3;
  localparam logic [2:0] CL_RESET = 3'h3;
  localparam logic [2:0] AL_RESET = 3'h0;
  // link cycles for dll lock before normal operation
  localparam logic [7:0] DLL_LOCK_CK = 8'hC8;
  // read scheduling depth in link cycles
  localparam int SCHED_DEPTH = 16;
endpackage

// *** verilog/ddi_sync3.sv ***
// ddi_sync3: three-stage synchroniser for pins from the link side.
// assumes: inputs are asynchronous to core_clk; output changes only
// once the second and third stages agree.
`timescale 1ns/1ps
`default_nettype none
module ddi_sync3 #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // pin side
  input wire logic [W-1:0] pin,
  // core side
  output logic [W-1:0] lvl
);
  logic [W-1:0] s1_q, s2_q, s3_q, lvl_q;
  logic [W-1:0] lvl_d;

  // take a bit only when stages two and three agree
  always_comb begin
    lvl_d = lvl_q;
    for (int i = 0; i < W; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        lvl_d[i] = s3_q[i];
      end
    end
  end

  // stage one feeds stage two only
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      lvl_q <= '0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  assign lvl = lvl_q;
endmodule
`default_nettype wire

// *** verilog/ddi_device.sv ***
// ddi_device: command-level model of a double-data-rate memory device.
// assumes: the controller keeps its own timing; mem_ck comes from it and
// is sampled here; registers are reached over apb.
//
// Chosen here: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module ddi_device
  import ddi_pkg::*;
#(
  parameter int DQ_W = 8,
  parameter int ROW_W = 14
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // command pins from the controller
  input wire logic mem_ck,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic bank_select_low,
  input wire logic bank_select_high,
  input wire logic [ROW_W-1:0] addr,
  // read data and strobe pins
  output logic [DQ_W-1:0] dq_o,
  output logic dq_oe,
  output logic dqs_o,
  output logic dqs_n_o,
  output logic dqs_oe
);
  localparam int PW = ROW_W + 7;

  // pins through the synchroniser, clock and command aligned
  logic [PW-1:0] pin_lvl;
  ddi_sync3 #(.W(PW)) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .pin({mem_ck, cs_n, ras_n, cas_n, we_n, bank_select_high,
          bank_select_low, addr}),
    .lvl(pin_lvl)
  );

  logic ck_q, ck_rise, ck_edge, cmd_vld;
  logic [2:0] cmd;
  logic [1:0] ba;
  logic [ROW_W-1:0] a;
  assign a = pin_lvl[ROW_W-1:0];
  assign ba = pin_lvl[ROW_W+1:ROW_W];
  assign cmd = pin_lvl[ROW_W+4:ROW_W+2];
  assign ck_rise = pin_lvl[PW-1] & ~ck_q;
  assign ck_edge = pin_lvl[PW-1] ^ ck_q;

  // register state
  logic en_q, en_d, ready_q, ready_d, dll_run_q, dll_run_d;
  logic [7:0] dll_cnt_q, dll_cnt_d;
  logic [2:0] cl_q, cl_d, al_q, al_d, cal_q, cal_d;
  logic bl8_q, bl8_d;
  logic [1:0] err_q, err_d;
  logic [3:0] open_q, open_d;
  logic [ROW_W-1:0] row_q [4], row_d [4];
  logic [4:0] apc_q [4], apc_d [4];
  // read path state
  logic [SCHED_DEPTH-1:0] sched_q, sched_d;
  logic [DQ_W-1:0] col_q [SCHED_DEPTH], col_d [SCHED_DEPTH];
  logic act_q, act_d, pre_q, pre_d;
  logic [2:0] left_q, left_d, idx_q, idx_d;
  logic [DQ_W-1:0] base_q, base_d, dq_q, dq_d;
  logic [3:0] rl;
  logic is_read, col_cmd;

  assign cmd_vld = ck_rise & ~pin_lvl[ROW_W+5] & en_q;
  assign is_read = cmd_vld & (cmd == CMD_READ);
  assign col_cmd = cmd_vld & (cmd == CMD_READ || cmd == CMD_WRITE);
  assign rl = 4'(al_q) + 4'(cl_q);

  // apb access strobes
  logic wr_en;
  assign wr_en = psel & penable & pwrite;

  // command decode, bank tracking, mode loads and dll wait
  always_comb begin
    en_d = en_q;
    ready_d = ready_q;
    dll_run_d = dll_run_q;
    dll_cnt_d = dll_cnt_q;
    cl_d = cl_q;
    al_d = al_q;
    cal_d = cal_q;
    bl8_d = bl8_q;
    open_d = open_q;
    err_d = err_q;
    row_d = row_q;
    apc_d = apc_q;
    if (wr_en && paddr == REG_CTRL) begin
      en_d = pwdata[CTRL_EN_BIT];
    end
    // clear first so a same-cycle event still sets
    if (wr_en && paddr == REG_ERR) begin
      err_d = err_q & ~pwdata[1:0];
    end
    if (ck_rise && dll_run_q) begin
      dll_cnt_d = dll_cnt_q - 8'h01;
      if (dll_cnt_q == 8'h01) begin
        dll_run_d = 1'b0;
        ready_d = 1'b1;
      end
    end
    // auto precharge countdown per bank
    for (int b = 0; b < 4; b++) begin
      if (ck_rise && apc_q[b] != 5'h00) begin
        apc_d[b] = apc_q[b] - 5'h01;
        if (apc_q[b] == 5'h01) begin
          open_d[b] = 1'b0;
        end
      end
    end
    if (cmd_vld) begin
      unique case (cmd)
        CMD_ACTIVATE: begin
          open_d[ba] = 1'b1;
          row_d[ba] = a;
        end
        CMD_PRECHARGE: begin
          if (a[AUTO_PRECHARGE_SELECT_BIT]) begin
            open_d = 4'h0;
          end else begin
            open_d[ba] = 1'b0;
          end
        end
        CMD_MODE: begin
          // register chosen by the bank selects
          if (ba == SEL_MAIN) begin
            bl8_d = (a[BL_LSB+:3] == BL8_CODE);
            cl_d = a[CL_LSB+:3];
            if (a[DLL_RESET_BIT]) begin
              dll_run_d = 1'b1;
              dll_cnt_d = DLL_LOCK_CK;
              ready_d = 1'b0;
            end
          end else if (ba == SEL_EXT) begin
            al_d = a[AL_LSB+:3];
            cal_d = a[DRIVE_CAL_LSB+:3];
          end
        end
        CMD_READ, CMD_WRITE: begin
          if (!open_q[ba]) begin
            err_d[ERR_IDLE_BIT] = 1'b1;
          end
          if (!ready_q) begin
            err_d[ERR_EARLY_BIT] = 1'b1;
          end
          // close after al plus half the burst
          if (cmd == CMD_READ && a[AUTO_PRECHARGE_SELECT_BIT]) begin
            apc_d[ba] = 5'(al_q) + (bl8_q ? 5'h04 : 5'h02);
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ck_q <= 1'b0;
      en_q <= CTRL_RESET[CTRL_EN_BIT];
      ready_q <= 1'b0;
      dll_run_q <= 1'b0;
      dll_cnt_q <= 8'h00;
      cl_q <= CL_RESET;
      al_q <= AL_RESET;
      cal_q <= 3'h0;
      bl8_q <= 1'b0;
      open_q <= 4'h0;
      err_q <= 2'h0;
      for (int b = 0; b < 4; b++) begin
        row_q[b] <= '0;
        apc_q[b] <= 5'h00;
      end
    end else begin
      ck_q <= pin_lvl[PW-1];
      en_q <= en_d;
      ready_q <= ready_d;
      dll_run_q <= dll_run_d;
      dll_cnt_q <= dll_cnt_d;
      cl_q <= cl_d;
      al_q <= al_d;
      cal_q <= cal_d;
      bl8_q <= bl8_d;
      open_q <= open_d;
      err_q <= err_d;
      row_q <= row_d;
      apc_q <= apc_d;
    end
  end

  // read scheduling and burst engine; a new start simply replaces the
  // running burst, which gives both seamless and truncated streams
  always_comb begin
    sched_d = sched_q;
    col_d = col_q;
    act_d = act_q;
    pre_d = pre_q;
    left_d = left_q;
    idx_d = idx_q;
    base_d = base_q;
    dq_d = dq_q;
    if (ck_rise) begin
      sched_d = sched_q >> 1;
      for (int i = 0; i < SCHED_DEPTH - 1; i++) begin
        col_d[i] = col_q[i+1];
      end
      if (is_read && rl != 4'h0) begin
        sched_d[rl-4'h1] = 1'b1;
        col_d[rl-4'h1] = DQ_W'(a) ^ DQ_W'(ba);
      end
      // a burst ending at this edge still leaves room for a preamble
      pre_d = sched_q[1] & ~(act_q & (left_q != 3'h0));
    end
    if (ck_edge) begin
      if (ck_rise && sched_q[0]) begin
        act_d = 1'b1;
        pre_d = 1'b0;
        left_d = bl8_q ? 3'h7 : 3'h3;
        idx_d = 3'h0;
        base_d = col_q[0];
        dq_d = col_q[0];
      end else if (act_q && left_q != 3'h0) begin
        left_d = left_q - 3'h1;
        idx_d = idx_q + 3'h1;
        dq_d = base_q + DQ_W'(idx_q + 3'h1);
      end else begin
        act_d = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sched_q <= '0;
      act_q <= 1'b0;
      pre_q <= 1'b0;
      left_q <= 3'h0;
      idx_q <= 3'h0;
      base_q <= '0;
      dq_q <= '0;
      for (int i = 0; i < SCHED_DEPTH; i++) begin
        col_q[i] <= '0;
      end
    end else begin
      sched_q <= sched_d;
      col_q <= col_d;
      act_q <= act_d;
      pre_q <= pre_d;
      left_q <= left_d;
      idx_q <= idx_d;
      base_q <= base_d;
      dq_q <= dq_d;
    end
  end

  // strobe high on even elements, low on odd ones and in the preamble
  assign dq_o = dq_q;
  assign dq_oe = act_q;
  assign dqs_oe = act_q | pre_q;
  assign dqs_o = act_q & ~idx_q[0];
  assign dqs_n_o = ~dqs_o;

  // apb read mux; zero-wait, unmapped reads zero with an error
  always_comb begin
    prdata = 32'h0000_0000;
    pslverr = 1'b0;
    unique case (paddr)
      REG_CTRL: prdata[CTRL_EN_BIT] = en_q;
      REG_STATUS: prdata[11:0] = {cal_q, open_q, dll_run_q, 3'h0, ready_q};
      REG_MODE: prdata[8:0] = {bl8_q, 1'b0, al_q, 1'b0, cl_q};
      REG_ERR: prdata[1:0] = err_q;
      default: pslverr = psel & penable;
    endcase
  end
  assign pready = 1'b1;

  property p_ready_after_lock;
    @(posedge core_clk) disable iff (rst)
      $rose(ready_q) |-> $past(dll_cnt_q) == 8'h01;
  endproperty
  a_ready_after_lock: assert property (p_ready_after_lock)
    else $error("ready raised before dll lock count ended");

  property p_prech_all;
    @(posedge core_clk) disable iff (rst)
      cmd_vld && cmd == CMD_PRECHARGE && a[AUTO_PRECHARGE_SELECT_BIT]
      |=> open_q == 4'h0;
  endproperty
  a_prech_all: assert property (p_prech_all)
    else $error("precharge all left a bank open");

  property p_first_data;
    @(posedge core_clk) disable iff (rst)
      ck_rise && sched_q[0] |=> act_q && idx_q == 3'h0 && dq_oe;
  endproperty
  a_first_data: assert property (p_first_data)
    else $error("first read element not driven at read latency");

  property p_preamble;
    @(posedge core_clk) disable iff (rst)
      pre_q |-> dqs_oe && !dqs_o && dqs_n_o && !dq_oe;
  endproperty
  a_preamble: assert property (p_preamble)
    else $error("strobe preamble wrong");

  property p_release;
    @(posedge core_clk) disable iff (rst)
      $fell(act_q) |-> !dq_oe && $past(left_q) == 3'h0;
  endproperty
  a_release: assert property (p_release)
    else $error("data released early or not at all");

  property p_seamless;
    @(posedge core_clk) disable iff (rst)
      ck_edge && act_q && left_q == 3'h0 && ck_rise && sched_q[0]
      |=> act_q && idx_q == 3'h0 ##1 act_q;
  endproperty
  a_seamless: assert property (p_seamless)
    else $error("gap between concatenated bursts");

  property p_truncate;
    @(posedge core_clk) disable iff (rst)
      ck_rise && sched_q[0] && act_q && left_q != 3'h0
      |=> idx_q == 3'h0 && left_q == (bl8_q ? 3'h7 : 3'h3);
  endproperty
  a_truncate: assert property (p_truncate)
    else $error("interrupting read did not restart burst");

  property p_idle_flag;
    @(posedge core_clk) disable iff (rst)
      col_cmd && !open_q[ba] |=> err_q[ERR_IDLE_BIT];
  endproperty
  a_idle_flag: assert property (p_idle_flag)
    else $error("column command to idle bank not flagged");

  // banks whose auto precharge ends at this link edge
  logic [3:0] apc_end;
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      apc_end[b] = ck_rise && apc_q[b] == 5'h01;
    end
  end

  property p_auto_close;
    @(posedge core_clk) disable iff (rst)
      apc_end != 4'h0 |=> (open_q & $past(apc_end)) == 4'h0;
  endproperty
  a_auto_close: assert property (p_auto_close)
    else $error("auto precharge did not close bank");
endmodule
`default_nettype wire

// *** verif/ddi_ctl_model.sv ***
// ddi_ctl_model: behavioural controller that drives the command pins.
// assumes: one cmd() call at a time; the link clock runs free.
`timescale 1ns/1ps
`default_nettype none
module ddi_ctl_model (
  // link clock and command pins
  output logic mem_ck,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic bank_select_low,
  output logic bank_select_high,
  output logic [13:0] addr,
  // read data and strobe from the device
  input wire logic [7:0] dq_o,
  input wire logic dq_oe,
  input wire logic dqs_o,
  input wire logic dqs_n_o,
  input wire logic dqs_oe
);
  int hc_s = 0;
  int last_hc = 0;
  int q_hc[$];
  logic [10:0] q_v[$];
  // phase offset keeps link edges away from core edges
  initial begin
    mem_ck = 1'b0;
    #3;
    forever #80 mem_ck = ~mem_ck;
  end
  // deselected from the start
  initial begin
    cs_n = 1'b1;
    {ras_n, cas_n, we_n} = 3'h7;
    {bank_select_high, bank_select_low} = 2'h0;
    addr = 14'h0000;
  end
  // sample late in each half cycle, past the device's sync delay
  always @(mem_ck) begin
    #56;
    hc_s = hc_s + 1;
    if (dq_oe || dqs_oe) begin
      q_hc.push_back(hc_s);
      q_v.push_back({dq_oe, dqs_o, dqs_n_o, dq_o});
    end
  end
  // pins move on the fall so they are settled around the rise
  task automatic cmd(input logic [2:0] c, input logic [1:0] ba,
                     input logic [13:0] a);
    @(negedge mem_ck);
    cs_n <= 1'b0;
    {ras_n, cas_n, we_n} <= c;
    {bank_select_high, bank_select_low} <= ba;
    addr <= a;
    @(posedge mem_ck);
    #60 last_hc = hc_s;
    @(negedge mem_ck);
    cs_n <= 1'b1;
    addr <= ~a; // no stale address while deselected
  endtask
endmodule
`default_nettype wire

// *** verif/ddr2_init_activate_read_tb.sv ***
// ddr2_init_activate_read_tb: self-checking bench for ddi_device.
// assumes: ddi_ctl_model drives the link; apb driven here.
`timescale 1ns/1ps
`default_nettype none
module ddr2_init_activate_read_tb;
  import ddi_pkg::*;
  typedef struct packed {
    logic [2:0] cl;
    logic [2:0] al;
    logic [1:0] ba;
    logic [13:0] a;
    logic [8:0] mode;
  } ddi_row_t;
  logic core_clk, rst, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic mem_ck, cs_n, ras_n, cas_n, we_n, bsl, bsh;
  logic [13:0] addr;
  logic [7:0] dq_o;
  logic dq_oe, dqs_o, dqs_n_o, dqs_oe;
  int n_fail = 0;
  int n_tests = 0;
  // banks 0 and 3 only: their index reads the same either way round
  ddi_row_t rows [4] = '{
    '{3'h3, 3'h0, 2'h3, 14'h0012, 9'h003},
    '{3'h4, 3'h1, 2'h0, 14'h00A5, 9'h014},
    '{3'h5, 3'h2, 2'h3, 14'h03F0, 9'h025},
    '{3'h3, 3'h3, 2'h0, 14'h0001, 9'h033}};

  ddi_device uut (.core_clk(core_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_ck(mem_ck),
    .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .bank_select_low(bsl), .bank_select_high(bsh), .addr(addr),
    .dq_o(dq_o), .dq_oe(dq_oe), .dqs_o(dqs_o), .dqs_n_o(dqs_n_o),
    .dqs_oe(dqs_oe));
  ddi_ctl_model ctl (.mem_ck(mem_ck), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .bank_select_low(bsl),
    .bank_select_high(bsh), .addr(addr), .dq_o(dq_o), .dq_oe(dq_oe),
    .dqs_o(dqs_o), .dqs_n_o(dqs_n_o), .dqs_oe(dqs_oe));

  // core clock, 8 ns
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // one apb transfer; read data and error taken at the ready edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic ck(input int n);
    repeat (n) @(posedge mem_ck);
  endtask

  // main then extended load; banks must be idle
  task automatic mode(input logic [2:0] cl, input logic [2:0] al,
                      input logic bl8);
    ctl.cmd(CMD_MODE, SEL_MAIN,
            {6'h00, 1'b0, cl, 1'b0, (bl8 ? BL8_CODE : 3'h2)});
    ctl.cmd(CMD_MODE, 2'h2, {4'h0, 3'h0, 1'b0, al, 3'h0});
    ck(2);
  endtask

  // one read, or two reads two link cycles apart, then check the stream
  task automatic rd2(input int rl, input logic [1:0] ba,
    input logic [13:0] a0, input int n0, input logic [13:0] a1,
    input int n1);
    int h0;
    int k;
    logic [7:0] b;
    ctl.q_hc.delete();
    ctl.q_v.delete();
    ctl.cmd(CMD_READ, ba, a0);
    h0 = ctl.last_hc;
    if (n1 > 0)
      ctl.cmd(CMD_READ, ba, a1);
    ck(rl + 8);
    chk(ctl.q_hc.size(), 2 + n0 + n1);
    for (int j = 0; j < ctl.q_hc.size() && j < 2 + n0 + n1; j++) begin
      k = j - 2;
      if (k < n0)
        b = (a0[7:0] ^ {6'h00, ba}) + 8'(k);
      else
        b = (a1[7:0] ^ {6'h00, ba}) + 8'(k - n0);
      chk(ctl.q_hc[j], h0 + 2 * rl - 2 + j);
      if (j < 2)
        chk(ctl.q_v[j][10:8], 3'h1);
      else
        chk(ctl.q_v[j], {1'b1, ~k[0], k[0], b});
    end
  endtask

  // hang guard, well past the expected run time
  initial begin
    #200000;
    n_fail++;
    end_of_test();
  end

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (12) @(posedge core_clk);
    chk({dq_oe, dqs_oe, dqs_n_o}, 3'h1);
    rst <= 1'b0;
    ck(1);
    apb(1'b0, REG_CTRL, 32'h0);
    chk(r, CTRL_RESET);
    apb(1'b0, 8'h10, 32'h0);
    chk({e, r[7:0]}, 9'h100);
    // closing steps of power-up
    ctl.cmd(CMD_PRECHARGE, 2'h0, 14'h0400);
    // third extended load must leave the live settings alone
    ctl.cmd(CMD_MODE, 2'h3, 14'h0000);
    apb(1'b0, REG_MODE, 32'h0);
    chk(r[8:0], 9'h003);
    ctl.cmd(CMD_REFRESH, 2'h0, 14'h0000);
    ctl.cmd(CMD_REFRESH, 2'h0, 14'h0000);
    ctl.cmd(CMD_MODE, SEL_MAIN, 14'h0132);
    apb(1'b0, REG_STATUS, 32'h0);
    chk({r[4], r[0]}, 2'h2);
    // early column access to an idle bank flags both errors
    ctl.cmd(CMD_READ, 2'h0, 14'h0000);
    ck(8);
    apb(1'b0, REG_ERR, 32'h0);
    chk(r[1:0], 2'h3);
    apb(1'b1, REG_ERR, 32'h3);
    apb(1'b0, REG_ERR, 32'h0);
    chk(r[1:0], 2'h0);
    ctl.cmd(CMD_MODE, SEL_MAIN, 14'h0032);
    ctl.cmd(CMD_MODE, 2'h2, 14'h0380);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(r[11:9], 3'h7);
    ctl.cmd(CMD_MODE, 2'h2, 14'h0000);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(r[11:9], 3'h0);
    ck(150);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(r[0], 1'b0);
    ck(40);
    apb(1'b0, REG_STATUS, 32'h0);
    chk({r[4], r[0]}, 2'h1);
    // latency table
    foreach (rows[i]) begin
      mode(rows[i].cl, rows[i].al, 1'b0);
      ctl.cmd(CMD_ACTIVATE, rows[i].ba, 14'h0155);
      ck(3);
      rd2(rows[i].al + rows[i].cl, rows[i].ba, rows[i].a, 4, 14'h0, 0);
      apb(1'b0, REG_MODE, 32'h0);
      chk(r[8:0], rows[i].mode);
      apb(1'b0, REG_STATUS, 32'h0);
      chk(r[8:5], 4'h1 << rows[i].ba);
      ctl.cmd(CMD_PRECHARGE, rows[i].ba, 14'h0000);
      ck(3);
    end
    // seamless pair, then burst eight cut short, then auto close
    mode(3'h3, 3'h0, 1'b0);
    ctl.cmd(CMD_ACTIVATE, 2'h3, 14'h0155);
    ck(3);
    rd2(3, 2'h3, 14'h0010, 4, 14'h0020, 4);
    ctl.cmd(CMD_PRECHARGE, 2'h3, 14'h0000);
    ck(3);
    mode(3'h3, 3'h0, 1'b1);
    ctl.cmd(CMD_ACTIVATE, 2'h3, 14'h0155);
    ck(3);
    rd2(3, 2'h3, 14'h0030, 4, 14'h0040, 8);
    rd2(3, 2'h3, 14'h0450, 8, 14'h0000, 0);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(r[8:5], 4'h0);
    // disabled device ignores the link
    apb(1'b1, REG_CTRL, 32'h0);
    ctl.cmd(CMD_ACTIVATE, 2'h0, 14'h0155);
    ck(2);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(r[8:5], 4'h0);
    apb(1'b1, REG_CTRL, 32'h1);
    end_of_test();
  end
endmodule
`default_nettype wire
